// File: hdl/ecpp_pkg.sv
package ecpp_pkg;
  // ---------------------------------------------------------------
  // Register offsets within each window
  // ---------------------------------------------------------------
  localparam logic [1:0] OFS_DATA = 2'h0;
  localparam logic [1:0] OFS_STATUS = 2'h1;
  localparam logic [1:0] OFS_CONTROL = 2'h2;
  localparam logic [1:0] OFS_FIFO = 2'h0;
  localparam logic [1:0] OFS_CAPB = 2'h1;
  localparam logic [1:0] OFS_EXTCTL = 2'h2;
  // ---------------------------------------------------------------
  // Port modes held in the extended control register
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_SPP = 3'h0;
  localparam logic [2:0] MODE_PS2 = 3'h1;
  localparam logic [2:0] MODE_COMPAT = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;
  // ---------------------------------------------------------------
  // Field positions and fixed values
  // ---------------------------------------------------------------
  localparam int DCR_STROBE = 0;
  localparam int DCR_AUTOFD = 1;
  localparam int DCR_INIT = 2;
  localparam int DCR_SELIN = 3;
  localparam int DCR_IRQEN = 4;
  localparam int DCR_DIR = 5;
  localparam logic [1:0] DCR_TOP_VAL = 2'h3;
  localparam logic [2:0] DSR_LOW_VAL = 3'h7;
  localparam logic [7:0] CAPA_VAL = 8'h10;
  localparam logic [7:0] CAPB_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'hFF;
  localparam logic [5:0] DCR_RST = 6'h00;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [2:0] ECR_LOW_RST = 3'h1;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_WIDTH = 13;
  // Idle pin levels: data 00, busy low, ack high, paper-error low, select high, fault high
  localparam logic [SYNC_WIDTH-1:0] PIN_IDLE = 13'h000B;
  // ---------------------------------------------------------------
  // Handshake engine states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FSETUP = 6'h02,
    ST_FSTB = 6'h04,
    ST_FEND = 6'h08,
    ST_RREQ = 6'h10,
    ST_RACK = 6'h20
  } ecpp_state_t;
endpackage

// File: hdl/ecpp_sync.sv
`timescale 1ns/1ps
module ecpp_sync #(
  parameter int WIDTH = 13,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import ecpp_pkg::*;
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("ecpp_sync WIDTH must be at least 1");
  end

  // Two-stage capture of pin levels
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// File: hdl/ecpp_fifo.sv
`timescale 1ns/1ps
module ecpp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clr_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  input wire logic pop_in,
  output logic [WIDTH-1:0] head_out,
  output logic full_out,
  output logic empty_out
);
  import ecpp_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [WIDTH-1:0] last_q;
  logic do_push;
  logic do_pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ecpp_fifo DEPTH must be a power of two, at least 2");
  end

  // Full refuses writes, empty refuses reads
  assign full_out = (cnt_q == (AW + 1)'(DEPTH));
  assign empty_out = (cnt_q == '0);
  assign do_push = push_in && !full_out;
  assign do_pop = pop_in && !empty_out;
  // Empty shows the byte that was read last
  assign head_out = empty_out ? last_q : mem[rd_q];

  // Storage array
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wr_q] <= push_data_in;
    end
  end

  // Pointers, fill count and last-read byte
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      last_q <= '0;
    end else if (clr_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
        last_q <= mem[rd_q];
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  AST_FULL_HOLDS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (full_out && push_in && !pop_in && !clr_in) |=> (full_out && $stable(wr_q)))
    else $error("full fifo took a byte");
endmodule

// File: hdl/ecpp_port.sv
`timescale 1ns/1ps
// Summary of operation
// - Forward bytes: port pulses strobe, peripheral answers on busy.
// - Reverse bytes: port lowers autofeed to request, peripheral answers on ack.
// - Select-in pin stays high for the whole of ECP mode.
// - Data latch clears on reset, drives pins uninverted, reads back.
// - ECP mode address-port writes enter the FIFO tagged, sent automatically, forward only.
// - Status bit 7 is inverted busy, bits 6-3 live pins, bits 2-0 one.
// - Control bits 7-6 read high, unwritable; bits 5-0 clear on reset.
// - Control bit 5 sets bus direction; forced low in mode 000.
// - With control bit 4 set, ack rising edge raises host interrupt.
// - Control bits 3,1,0 drive pins inverted, bit 2 uninverted.
// - Mode 010 FIFO bytes go out by standard handshake, forward only.
// - Mode 011 sends FIFO forward or fetches peripheral bytes, per direction.
// - Mode 110 FIFO reads and writes freely, data shown without handshake.
// - Full test FIFO ignores writes; empty read returns last byte read.
// - Capability word A reads 10h in mode 111, read-only.
// - Capability word B is read-only and reads all zero bits in mode 111, FFh in other modes.
// - Port mode sits in extended control bits 7-5.
// - One 16-byte FIFO serves data, address and test ports, both ways.
module ecpp_port #(
  parameter int DEPTH = ecpp_pkg::FIFO_DEPTH
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic HOST_BASE2_IN,
  input wire logic [1:0] HOST_ADDR_IN,
  input wire logic HOST_WR_IN,
  input wire logic HOST_RD_IN,
  input wire logic [7:0] HOST_WDATA_IN,
  output logic [7:0] HOST_RDATA_OUT,
  output logic HOST_IRQ_OUT,
  input wire logic [7:0] PD_IN,
  output logic [7:0] PD_OUT,
  output logic PD_OE_OUT,
  output logic STROBE_N_OUT,
  output logic AUTOFD_N_OUT,
  output logic INIT_N_OUT,
  output logic SELECTIN_N_OUT,
  input wire logic BUSY_IN,
  input wire logic ACK_N_IN,
  input wire logic PERROR_IN,
  input wire logic SELECT_IN,
  input wire logic FAULT_N_IN
);
  import ecpp_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [SYNC_WIDTH-1:0] pins_s;
  logic [7:0] pd_s;
  logic busy_s, ack_n_s, perror_s, select_s, fault_n_s;
  logic ack_n_d1_q;
  logic [7:0] latch_q;
  logic [5:0] dcr_q;
  logic [2:0] mode_q;
  logic [2:0] ecr_low_q;
  ecpp_state_t state_q;
  logic [7:0] byte_q;
  logic tag_q;
  logic wr1, wr2, rd1, rd2;
  logic fwd_en, rev_en, auto_mode;
  logic host_push, host_pop, eng_push, eng_pop;
  logic fifo_push, fifo_pop, fifo_full, fifo_empty;
  logic [8:0] push_word;
  logic [8:0] head;

  // Decode of window and offset for one access
  function automatic logic hit(input logic base2, input logic [1:0] ofs, input logic want2,
                               input logic [1:0] want);
    return (base2 == want2) && (ofs == want);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Reset to idle pin levels, so no false ack edge follows reset
  ecpp_sync #(.WIDTH(SYNC_WIDTH), .RST_VAL(PIN_IDLE)) u_sync (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .async_in({PD_IN, BUSY_IN, ACK_N_IN, PERROR_IN, SELECT_IN, FAULT_N_IN}),
    .sync_out(pins_s)
  );
  assign pd_s = pins_s[12:5];
  assign busy_s = pins_s[4];
  assign ack_n_s = pins_s[3];
  assign perror_s = pins_s[2];
  assign select_s = pins_s[1];
  assign fault_n_s = pins_s[0];

  // ---------------------------------------------------------------
  // Access decode and transfer enables
  // ---------------------------------------------------------------
  assign wr1 = HOST_WR_IN && !HOST_BASE2_IN;
  assign wr2 = HOST_WR_IN && HOST_BASE2_IN;
  assign rd1 = HOST_RD_IN && !HOST_BASE2_IN;
  assign rd2 = HOST_RD_IN && HOST_BASE2_IN;
  assign fwd_en = (mode_q == MODE_COMPAT) || (mode_q == MODE_ECP && !dcr_q[DCR_DIR]);
  assign rev_en = (mode_q == MODE_ECP) && dcr_q[DCR_DIR];
  assign auto_mode = (mode_q == MODE_COMPAT) || (mode_q == MODE_ECP);

  // Host side of the shared FIFO
  always_comb begin
    host_push = 1'b0;
    push_word = {1'b0, HOST_WDATA_IN};
    if (HOST_WR_IN && hit(HOST_BASE2_IN, HOST_ADDR_IN, 1'b0, OFS_DATA) && mode_q == MODE_ECP) begin
      host_push = !dcr_q[DCR_DIR];
      push_word = {1'b1, HOST_WDATA_IN};
    end else if (HOST_WR_IN && hit(HOST_BASE2_IN, HOST_ADDR_IN, 1'b1, OFS_FIFO)) begin
      host_push = fwd_en || (mode_q == MODE_TEST);
    end
    // Engine byte wins; a stray host write must not replace it
    if (eng_push) begin
      push_word = {busy_s, pd_s};
    end
  end
  assign host_pop = HOST_RD_IN && hit(HOST_BASE2_IN, HOST_ADDR_IN, 1'b1, OFS_FIFO) &&
                    (rev_en || mode_q == MODE_TEST);
  assign fifo_push = host_push || eng_push;
  assign fifo_pop = host_pop || eng_pop;

  // Single FIFO for data, address and test ports
  ecpp_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .clr_in(mode_q == MODE_SPP),
    .push_in(fifo_push),
    .push_data_in(push_word),
    .pop_in(fifo_pop),
    .head_out(head),
    .full_out(fifo_full),
    .empty_out(fifo_empty)
  );

  // ---------------------------------------------------------------
  // Registers written by the host
  // ---------------------------------------------------------------
  // Parallel data latch
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      latch_q <= BYTE_RST;
    end else if (wr1 && HOST_ADDR_IN == OFS_DATA && mode_q != MODE_ECP) begin
      latch_q <= HOST_WDATA_IN;
    end
  end

  // Control bits, direction forced forward in mode 000
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dcr_q <= DCR_RST;
    end else if (wr1 && HOST_ADDR_IN == OFS_CONTROL) begin
      dcr_q <= {HOST_WDATA_IN[DCR_DIR] && mode_q != MODE_SPP, HOST_WDATA_IN[4:0]};
    end else if (mode_q == MODE_SPP) begin
      dcr_q[DCR_DIR] <= 1'b0;
    end
  end

  // Extended control: mode and plain bits
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_q <= MODE_RST;
      ecr_low_q <= ECR_LOW_RST;
    end else if (wr2 && HOST_ADDR_IN == OFS_EXTCTL) begin
      mode_q <= HOST_WDATA_IN[7:5];
      ecr_low_q <= HOST_WDATA_IN[4:2];
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      HOST_RDATA_OUT <= BYTE_RST;
    end else if (rd1) begin
      if (HOST_ADDR_IN == OFS_DATA) begin
        HOST_RDATA_OUT <= (mode_q == MODE_PS2 && dcr_q[DCR_DIR]) ? pd_s : latch_q;
      end else if (HOST_ADDR_IN == OFS_STATUS) begin
        HOST_RDATA_OUT <= {~busy_s, ack_n_s, perror_s, select_s, fault_n_s, DSR_LOW_VAL};
      end else if (HOST_ADDR_IN == OFS_CONTROL) begin
        HOST_RDATA_OUT <= {DCR_TOP_VAL, dcr_q};
      end else begin
        HOST_RDATA_OUT <= UNMAPPED_VAL;
      end
    end else if (rd2) begin
      if (HOST_ADDR_IN == OFS_FIFO) begin
        HOST_RDATA_OUT <= (mode_q == MODE_CONFIG) ? CAPA_VAL : head[7:0];
      end else if (HOST_ADDR_IN == OFS_CAPB) begin
        HOST_RDATA_OUT <= (mode_q == MODE_CONFIG) ? CAPB_VAL : UNMAPPED_VAL;
      end else if (HOST_ADDR_IN == OFS_EXTCTL) begin
        HOST_RDATA_OUT <= {mode_q, ecr_low_q, fifo_full, fifo_empty};
      end else begin
        HOST_RDATA_OUT <= UNMAPPED_VAL;
      end
    end
  end

  // Interrupt pulse on rising ack edge
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_n_d1_q <= 1'b1;
      HOST_IRQ_OUT <= 1'b0;
    end else begin
      ack_n_d1_q <= ack_n_s;
      HOST_IRQ_OUT <= dcr_q[DCR_IRQEN] && ack_n_s && !ack_n_d1_q;
    end
  end

  // ---------------------------------------------------------------
  // Automatic handshake engine
  // ---------------------------------------------------------------
  assign eng_pop = (state_q == ST_IDLE) && fwd_en && !fifo_empty;
  assign eng_push = (state_q == ST_RREQ) && rev_en && !ack_n_s;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_IDLE;
      byte_q <= BYTE_RST;
      tag_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (eng_pop) begin
            byte_q <= head[7:0];
            tag_q <= head[8] && mode_q == MODE_ECP;
            state_q <= ST_FSETUP;
          end else if (rev_en && !fifo_full) begin
            state_q <= ST_RREQ;
          end
        end
        ST_FSETUP: begin
          if (!fwd_en) begin
            state_q <= ST_IDLE;
          end else if (!busy_s) begin
            state_q <= ST_FSTB;
          end
        end
        ST_FSTB: begin
          if (!fwd_en || busy_s) begin
            state_q <= ST_FEND;
          end
        end
        ST_FEND: begin
          if (!fwd_en || !busy_s) begin
            state_q <= ST_IDLE;
          end
        end
        ST_RREQ: begin
          if (!rev_en) begin
            state_q <= ST_IDLE;
          end else if (!ack_n_s) begin
            state_q <= ST_RACK;
          end
        end
        ST_RACK: begin
          if (!rev_en || ack_n_s) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      STROBE_N_OUT <= 1'b1;
      AUTOFD_N_OUT <= 1'b1;
      INIT_N_OUT <= 1'b0;
      SELECTIN_N_OUT <= 1'b1;
    end else begin
      STROBE_N_OUT <= auto_mode ? (state_q != ST_FSTB) : ~dcr_q[DCR_STROBE];
      if (!auto_mode) begin
        AUTOFD_N_OUT <= ~dcr_q[DCR_AUTOFD];
      end else if (state_q == ST_RREQ) begin
        AUTOFD_N_OUT <= 1'b0;
      end else if (state_q == ST_FSETUP || state_q == ST_FSTB || state_q == ST_FEND) begin
        AUTOFD_N_OUT <= !tag_q;
      end else begin
        AUTOFD_N_OUT <= 1'b1;
      end
      INIT_N_OUT <= dcr_q[DCR_INIT];
      SELECTIN_N_OUT <= (mode_q == MODE_ECP) ? 1'b1 : ~dcr_q[DCR_SELIN];
    end
  end

  // Data bus value and direction
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PD_OUT <= BYTE_RST;
      PD_OE_OUT <= 1'b1;
    end else begin
      if (mode_q == MODE_TEST) begin
        PD_OUT <= head[7:0];
      end else if (auto_mode && state_q != ST_IDLE) begin
        PD_OUT <= byte_q;
      end else begin
        PD_OUT <= latch_q;
      end
      PD_OE_OUT <= (mode_q == MODE_SPP || mode_q == MODE_COMPAT) ? 1'b1 : !dcr_q[DCR_DIR];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_SELIN_ECP: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (mode_q == MODE_ECP && $past(mode_q) == MODE_ECP) |-> SELECTIN_N_OUT)
    else $error("select-in low in ECP mode");
  AST_DCR_TOP: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rd1 && HOST_ADDR_IN == OFS_CONTROL) |=> (HOST_RDATA_OUT[7:6] == DCR_TOP_VAL))
    else $error("control top bits not high");
  AST_DSR_READ: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rd1 && HOST_ADDR_IN == OFS_STATUS) |=> (HOST_RDATA_OUT == {~$past(busy_s), $past(ack_n_s),
      $past(perror_s), $past(select_s), $past(fault_n_s), DSR_LOW_VAL}))
    else $error("status read wrong");
  AST_DIR_SPP: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (mode_q == MODE_SPP) |=> !dcr_q[DCR_DIR] || mode_q != MODE_SPP)
    else $error("direction not forced in mode 000");
  AST_CAPA: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rd2 && HOST_ADDR_IN == OFS_FIFO && mode_q == MODE_CONFIG) |=> (HOST_RDATA_OUT == CAPA_VAL))
    else $error("capability A wrong");
  AST_CAPB: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (rd2 && HOST_ADDR_IN == OFS_CAPB && mode_q == MODE_CONFIG) |=> (HOST_RDATA_OUT == CAPB_VAL))
    else $error("capability B wrong");
  AST_IRQ_EDGE: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (dcr_q[DCR_IRQEN] && $rose(ack_n_s)) |=> HOST_IRQ_OUT)
    else $error("ack edge lost");
  AST_LATCH_PINS: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (wr1 && HOST_ADDR_IN == OFS_DATA && mode_q == MODE_SPP ##1 !wr1 && mode_q == MODE_SPP)
    |=> (PD_OUT == $past(HOST_WDATA_IN, 2)))
    else $error("latch not on pins");
  AST_INIT_PIN: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (mode_q == MODE_SPP && $past(mode_q) == MODE_SPP) |-> (INIT_N_OUT == $past(dcr_q[DCR_INIT])
      && STROBE_N_OUT == !$past(dcr_q[DCR_STROBE])))
    else $error("control pins wrong");
  AST_FWD_STROBE: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (state_q == ST_FSTB && fwd_en) |=> !STROBE_N_OUT)
    else $error("strobe not low in transfer");
  AST_REV_REQ: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (state_q == ST_RREQ && rev_en) |=> !AUTOFD_N_OUT)
    else $error("reverse request not shown");
endmodule

// File: tb/ecpp_periph_model.sv
`timescale 1ns/1ps
// Peripheral at the far side of the parallel pins
module ecpp_periph_model #(
  parameter logic [7:0] FIRST_BYTE = 8'h5A
) (
  input wire logic clk_in,
  input wire logic [3:0] lag_in,
  input wire logic strobe_n_in,
  input wire logic autofd_n_in,
  input wire logic init_n_in,
  input wire logic selectin_n_in,
  input wire logic [7:0] pd_out_in,
  input wire logic pd_oe_in,
  output logic busy_out,
  output logic ack_n_out,
  output logic perror_out,
  output logic [7:0] pd_in_out
);
  logic [8:0] rx_q[$];
  logic [7:0] tx_q = FIRST_BYTE;
  int wait_n = 0;
  initial begin
    busy_out = 1'b0;
    ack_n_out = 1'b1;
  end
  // Answer init low with paper-error low
  assign perror_out = init_n_in;
  // Drive only when allowed; otherwise port byte or a moving pattern
  assign pd_in_out = (!init_n_in && selectin_n_in && !pd_oe_in) ? tx_q : (pd_oe_in ? pd_out_in : ~tx_q);
  // Both handshakes, each step held off by the lag
  always @(posedge clk_in) begin
    if (wait_n > 0) begin
      wait_n <= wait_n - 1;
    end else if (!strobe_n_in && !busy_out) begin
      rx_q.push_back({!autofd_n_in, pd_out_in});
      busy_out <= 1'b1;
      wait_n <= int'(lag_in);
    end else if (strobe_n_in && busy_out) begin
      busy_out <= 1'b0;
      wait_n <= int'(lag_in);
    end else if (!autofd_n_in && ack_n_out && !pd_oe_in) begin
      ack_n_out <= 1'b0;
      wait_n <= int'(lag_in);
    end else if (autofd_n_in && !ack_n_out) begin
      ack_n_out <= 1'b1;
      tx_q <= tx_q + 8'h01;
      wait_n <= int'(lag_in);
    end
  end
endmodule

// File: tb/test_ecp_parallel_port_regs.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_ecp_parallel_port_regs;
  import ecpp_pkg::*;
  localparam logic [7:0] REV_FIRST = 8'h5A;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic base2 = 1'b0;
  logic [1:0] addr = 2'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic sel = 1'b1;
  logic fault_n = 1'b1;
  logic [3:0] lag = 4'h0;
  logic [7:0] rdata, pd_out, pd_in, v;
  logic irq, pd_oe, strobe_n, autofd_n, init_n, selin_n, busy, ack_n, perror;
  logic [7:0] q[$];
  int errors = 0;
  int check_count = 0;
  int irq_cnt = 0;
  int ack_rise = 0;
  // Clock
  always #12.5 clk = ~clk;
  ecpp_port #(.DEPTH(FIFO_DEPTH)) u_dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .HOST_BASE2_IN(base2),
    .HOST_ADDR_IN(addr), .HOST_WR_IN(wr), .HOST_RD_IN(rd), .HOST_WDATA_IN(wdata), .HOST_RDATA_OUT(rdata),
    .HOST_IRQ_OUT(irq), .PD_IN(pd_in), .PD_OUT(pd_out), .PD_OE_OUT(pd_oe), .STROBE_N_OUT(strobe_n),
    .AUTOFD_N_OUT(autofd_n), .INIT_N_OUT(init_n), .SELECTIN_N_OUT(selin_n), .BUSY_IN(busy),
    .ACK_N_IN(ack_n), .PERROR_IN(perror), .SELECT_IN(sel), .FAULT_N_IN(fault_n));
  ecpp_periph_model #(.FIRST_BYTE(REV_FIRST)) u_peri (.clk_in(clk), .lag_in(lag), .strobe_n_in(strobe_n),
    .autofd_n_in(autofd_n), .init_n_in(init_n), .selectin_n_in(selin_n), .pd_out_in(pd_out),
    .pd_oe_in(pd_oe), .busy_out(busy), .ack_n_out(ack_n), .perror_out(perror), .pd_in_out(pd_in));
  // Count interrupt pulses and acknowledge rising edges
  always @(posedge clk) if (irq === 1'b1) irq_cnt++;
  always @(posedge ack_n) ack_rise++;
  task automatic wr_reg(input logic b2, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    base2 <= b2;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk_rd(input string nm, input logic b2, input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    base2 <= b2;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
    `CHK(nm, e, v)
  endtask
  task automatic set_mode(input logic [2:0] m);
    wr_reg(1'b1, OFS_EXTCTL, {m, ECR_LOW_RST, 2'b00});
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 2000 && u_peri.rx_q.size() < n; i++) @(posedge clk);
    `CHK("rx_count", n, u_peri.rx_q.size())
  endtask
  // Expected status byte from the pin levels
  function automatic logic [7:0] status_exp(input logic b, input logic a, input logic p, input logic s,
                                            input logic f);
    return {~b, a, p, s, f, DSR_LOW_VAL};
  endfunction
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #(25 * 20000);
    errors++;
    test_done();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h0CCE03D1));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd("data_rst", 1'b0, OFS_DATA, BYTE_RST);
    chk_rd("ctl_rst", 1'b0, OFS_CONTROL, {DCR_TOP_VAL, DCR_RST});
    `CHK("pins_rst", 4'hD, {strobe_n, autofd_n, init_n, selin_n})
    tend("reset");
    for (int i = 0; i < 4; i++) begin
      wr_reg(1'b0, OFS_DATA, (i == 0) ? 8'hFF : 8'($urandom));
      chk_rd("data_rd", 1'b0, OFS_DATA, wdata);
      `CHK("data_pins", wdata, pd_out)
      `CHK("data_oe", 1'b1, pd_oe)
    end
    for (int i = 0; i < 6; i++) begin
      wr_reg(1'b0, OFS_CONTROL, (i == 0) ? 8'h3F : 8'($urandom));
      chk_rd("ctl_rd", 1'b0, OFS_CONTROL, {DCR_TOP_VAL, 1'b0, wdata[4:0]});
      `CHK("ctl_pins", {~wdata[0], ~wdata[1], wdata[2], ~wdata[3]}, {strobe_n, autofd_n, init_n, selin_n})
    end
    wr_reg(1'b0, OFS_CONTROL, 8'h04);
    repeat (20) @(posedge clk);
    u_peri.rx_q.delete();
    tend("latch_control");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      sel <= 1'($urandom);
      fault_n <= 1'($urandom);
      repeat (4) @(posedge clk);
      chk_rd("status", 1'b0, OFS_STATUS, status_exp(busy, ack_n, perror, sel, fault_n));
    end
    tend("status");
    lag <= 4'h3;
    set_mode(MODE_COMPAT);
    for (int i = 0; i < 3; i++) begin
      q.push_back(8'($urandom));
      wr_reg(1'b1, OFS_FIFO, q[i]);
    end
    wait_rx(3);
    foreach (q[i]) `CHK("compat_tx", {1'b0, q[i]}, u_peri.rx_q[i])
    tend("compat");
    set_mode(MODE_SPP);
    wr_reg(1'b0, OFS_CONTROL, 8'h0C);
    set_mode(MODE_ECP);
    u_peri.rx_q.delete();
    lag <= 4'h9;
    v = 8'($urandom);
    wr_reg(1'b0, OFS_DATA, v);
    wr_reg(1'b1, OFS_FIFO, ~v);
    `CHK("selin_ecp", 1'b1, selin_n)
    wait_rx(2);
    `CHK("addr_tx", {1'b1, v}, u_peri.rx_q[0])
    `CHK("ecp_tx", {1'b0, ~v}, u_peri.rx_q[1])
    tend("ecp_forward");
    lag <= 4'h2;
    set_mode(MODE_PS2);
    wr_reg(1'b0, OFS_CONTROL, 8'h30);
    repeat (4) @(posedge clk);
    chk_rd("ps2_rd", 1'b0, OFS_DATA, REV_FIRST);
    irq_cnt = 0;
    ack_rise = 0;
    set_mode(MODE_ECP);
    repeat (300) @(posedge clk);
    `CHK("rev_oe", 1'b0, pd_oe)
    for (int i = 0; i < 5; i++) chk_rd("ecp_rx", 1'b1, OFS_FIFO, REV_FIRST + 8'(i));
    set_mode(MODE_PS2);
    repeat (20) @(posedge clk);
    `CHK("ack_seen", 1'b1, ack_rise > 4)
    `CHK("irq_count", ack_rise, irq_cnt)
    tend("ecp_reverse");
    set_mode(MODE_SPP);
    wr_reg(1'b0, OFS_CONTROL, 8'h04);
    set_mode(MODE_TEST);
    q.delete();
    for (int i = 0; i < FIFO_DEPTH + 2; i++) begin
      q.push_back(8'($urandom));
      wr_reg(1'b1, OFS_FIFO, q[i]);
    end
    repeat (2) @(posedge clk);
    #1;
    `CHK("test_head", q[0], pd_out)
    for (int i = 0; i < FIFO_DEPTH; i++) chk_rd("test_rd", 1'b1, OFS_FIFO, q[i]);
    chk_rd("test_empty", 1'b1, OFS_FIFO, q[FIFO_DEPTH-1]);
    tend("test_fifo");
    set_mode(MODE_CONFIG);
    wr_reg(1'b1, OFS_FIFO, 8'hEF);
    wr_reg(1'b1, OFS_CAPB, 8'hFF);
    chk_rd("capa", 1'b1, OFS_FIFO, CAPA_VAL);
    chk_rd("capb", 1'b1, OFS_CAPB, CAPB_VAL);
    chk_rd("unmapped", 1'b0, 2'h3, UNMAPPED_VAL);
    chk_rd("ecr_rd", 1'b1, OFS_EXTCTL, {MODE_CONFIG, ECR_LOW_RST, 1'b0, 1'b1});
    tend("config");
    test_done();
  end
endmodule
